// File: core/gcm_pkg.sv
// Package for the control-input pin function multiplexer
package gcm_pkg;
   localparam int NUM_PINS = 7;
   localparam int NUM_REFS = 8;
   localparam int NUM_LOOPS = 3;
   localparam int CODE_W = 7;
   localparam int REG_W = 8;
   localparam logic [7:0] FUNC_SEL_RESET = 8'h00;
   localparam logic [6:0] CODE_PLAIN = 7'h00;
   localparam logic [6:0] CODE_LOS_BASE = 7'h10;
   localparam logic [6:0] CODE_LOS_LAST = 7'h17;
   localparam logic [6:0] CODE_TIE_L0 = 7'h20;
   localparam logic [6:0] CODE_TIE_L1 = 7'h28;
   localparam logic [6:0] CODE_TIE_L2 = 7'h30;
   localparam logic [6:0] CODE_HALT_B1 = 7'h44;
   localparam logic [6:0] CODE_HALT_B0 = 7'h45;
   localparam int STRAP_HOLD_MS = 125;

   typedef struct packed {
      logic [7:0] loss_of_signal;
      logic [2:0] tie_clear_en;
      logic [1:0] halt;
   } gcm_route_s;
endpackage : gcm_pkg

// File: core/gcm_pin_sync.sv
// Two-stage synchroniser for one pin
module gcm_pin_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pin and result
   input wire logic din,
   output logic dout
);
   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;

   always_comb begin
      meta_d = din;
      sync_d = meta_q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign dout = sync_q;
endmodule : gcm_pin_sync

// File: core/gcm_top.sv
// Control-input function multiplexer for general purpose pins
module gcm_top #(
   parameter int NUM_PINS = gcm_pkg::NUM_PINS
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // Function register write and read port
   input wire logic FSEL_WR,
   input wire logic [$clog2(NUM_PINS)-1:0] FSEL_ADDR,
   input wire logic [gcm_pkg::REG_W-1:0] FSEL_WDATA,
   output logic [gcm_pkg::REG_W-1:0] FSEL_RDATA,
   // Pins
   input wire logic [NUM_PINS-1:0] GPIO_IN,
   // Register bits that are ORed with the pins
   input wire logic [gcm_pkg::NUM_LOOPS-1:0] LOOP_TIE_CLR_REG,
   input wire logic [1:0] SYNTH_HALT_REG,
   // Reference state
   input wire logic [gcm_pkg::NUM_REFS-1:0] REF_MON_FAIL,
   input wire logic [gcm_pkg::NUM_REFS-1:0] REF_VALID_MASK,
   input wire logic [gcm_pkg::NUM_LOOPS*3-1:0] LOOP_REF_SEL,
   // Routed results
   output gcm_pkg::gcm_route_s ROUTE,
   output logic [gcm_pkg::NUM_REFS-1:0] REF_FAILED,
   output logic [gcm_pkg::NUM_LOOPS*3-1:0] LOOP_ACTIVE_REF,
   output logic [gcm_pkg::NUM_LOOPS-1:0] LOOP_HOLDOVER
);
   localparam int NR = gcm_pkg::NUM_REFS;
   localparam int NL = gcm_pkg::NUM_LOOPS;

   logic [gcm_pkg::REG_W-1:0] fsel_q [NUM_PINS];
   logic [gcm_pkg::REG_W-1:0] fsel_d [NUM_PINS];
   logic [gcm_pkg::REG_W-1:0] rdata_q;
   logic [gcm_pkg::REG_W-1:0] rdata_d;
   logic addr_ok;
   logic [NUM_PINS-1:0] pin_s;
   gcm_pkg::gcm_route_s route_q;
   gcm_pkg::gcm_route_s route_d;
   logic [NR-1:0] fail_q;
   logic [NR-1:0] fail_d;
   logic [NR-1:0] good_ref;
   logic [2:0] first_good;
   logic any_good;
   logic [NL*3-1:0] act_q;
   logic [NL*3-1:0] act_d;
   logic [NL-1:0] hold_q;
   logic [NL-1:0] hold_d;

   // Pin synchronisers
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_sync
         gcm_pin_sync u_sync (
            .clk(CLK_SYS),
            .rst_n(RST_N),
            .din(GPIO_IN[g]),
            .dout(pin_s[g])
         );
      end
   endgenerate

   // An index with no register behind it is not written and reads the reset value
   assign addr_ok = int'(FSEL_ADDR) < NUM_PINS;

   // Function register file
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         fsel_d[i] = fsel_q[i];
      end
      rdata_d = gcm_pkg::FUNC_SEL_RESET;
      if (FSEL_WR && addr_ok) begin
         fsel_d[FSEL_ADDR] = FSEL_WDATA;
      end
      if (addr_ok) begin
         rdata_d = fsel_q[FSEL_ADDR];
      end
   end

   // Function registers and registered read data
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            fsel_q[i] <= gcm_pkg::FUNC_SEL_RESET;
         end
         rdata_q <= gcm_pkg::FUNC_SEL_RESET;
      end else begin
         for (int i = 0; i < NUM_PINS; i++) begin
            fsel_q[i] <= fsel_d[i];
         end
         rdata_q <= rdata_d;
      end
   end

   // Code decode and OR with register bits
   // Several pins carrying one code are ORed; undefined codes fall to the default
   always_comb begin
      logic [gcm_pkg::CODE_W-1:0] code;
      code = gcm_pkg::CODE_PLAIN;
      route_d.loss_of_signal = '0;
      route_d.tie_clear_en = LOOP_TIE_CLR_REG;
      route_d.halt = SYNTH_HALT_REG;
      for (int i = 0; i < NUM_PINS; i++) begin
         code = fsel_q[i][gcm_pkg::CODE_W-1:0];
         unique case (code) inside
            gcm_pkg::CODE_PLAIN: begin
            end
            [gcm_pkg::CODE_LOS_BASE:gcm_pkg::CODE_LOS_LAST]: begin
               route_d.loss_of_signal[code[2:0]] |= pin_s[i];
            end
            gcm_pkg::CODE_TIE_L0: begin
               route_d.tie_clear_en[0] |= pin_s[i];
            end
            gcm_pkg::CODE_TIE_L1: begin
               route_d.tie_clear_en[1] |= pin_s[i];
            end
            gcm_pkg::CODE_TIE_L2: begin
               route_d.tie_clear_en[2] |= pin_s[i];
            end
            gcm_pkg::CODE_HALT_B1: begin
               route_d.halt[1] |= pin_s[i];
            end
            gcm_pkg::CODE_HALT_B0: begin
               route_d.halt[0] |= pin_s[i];
            end
            default: begin
            end
         endcase
      end
   end

   // Reference failure: monitor fail or routed loss-of-signal
   always_comb begin
      fail_d = REF_MON_FAIL | route_q.loss_of_signal;
   end

   // Usable references and the lowest-index one among them
   always_comb begin
      good_ref = ~fail_q & REF_VALID_MASK;
      first_good = 3'h0;
      any_good = |good_ref;
      for (int r = NR - 1; r >= 0; r--) begin
         if (good_ref[r]) begin
            first_good = 3'(r);
         end
      end
   end

   // Loop switchover and holdover
   // Revertive: a loop goes back to its preferred reference once that one is good
   // In holdover the last active reference is kept so the loop resumes from it
   always_comb begin
      logic [2:0] cur;
      logic [2:0] prev;
      cur = 3'h0;
      prev = 3'h0;
      act_d = act_q;
      hold_d = hold_q;
      for (int l = 0; l < NL; l++) begin
         cur = LOOP_REF_SEL[l*3 +: 3];
         prev = act_q[l*3 +: 3];
         if (good_ref[cur]) begin
            act_d[l*3 +: 3] = cur;
            hold_d[l] = 1'b0;
         end else if (good_ref[prev]) begin
            hold_d[l] = 1'b0;
         end else if (any_good) begin
            act_d[l*3 +: 3] = first_good;
            hold_d[l] = 1'b0;
         end else begin
            hold_d[l] = 1'b1;
         end
      end
   end

   // Routed signal register
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         route_q <= '0;
      end else begin
         route_q <= route_d;
      end
   end

   // Failed reference register
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         fail_q <= '0;
      end else begin
         fail_q <= fail_d;
      end
   end

   // Loop state registers
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         act_q <= '0;
         hold_q <= '0;
      end else begin
         act_q <= act_d;
         hold_q <= hold_d;
      end
   end

   // Every output leaves straight from a register
   assign FSEL_RDATA = rdata_q;
   assign ROUTE = route_q;
   assign REF_FAILED = fail_q;
   assign LOOP_ACTIVE_REF = act_q;
   assign LOOP_HOLDOVER = hold_q;
endmodule : gcm_top

// File: dv/gcm_board.sv
// Board logic model driving the general purpose pins
module gcm_board #(parameter int HOLD = 20) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Wanted levels and pins
   input wire logic [6:0] want,
   output logic [6:0] pins
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) cnt <= 0;
      else if (cnt < HOLD) cnt <= cnt + 1;
   end
   assign pins = (cnt < HOLD) ? 7'h00 : want;
endmodule : gcm_board

// File: dv/gcm_checker.sv
// Assertion checker for the pin function multiplexer
module gcm_checker #(parameter int NUM_PINS = gcm_pkg::NUM_PINS) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // Register port
   input wire logic FSEL_WR,
   input wire logic [$clog2(NUM_PINS)-1:0] FSEL_ADDR,
   input wire logic [7:0] FSEL_WDATA,
   input wire logic [7:0] FSEL_RDATA,
   // Pins and register bits
   input wire logic [NUM_PINS-1:0] GPIO_IN,
   input wire logic [2:0] LOOP_TIE_CLR_REG,
   input wire logic [1:0] SYNTH_HALT_REG,
   input wire logic [7:0] REF_MON_FAIL,
   input wire logic [7:0] REF_VALID_MASK,
   // Results
   input wire gcm_pkg::gcm_route_s ROUTE,
   input wire logic [7:0] REF_FAILED,
   input wire logic [2:0] LOOP_HOLDOVER
);
   logic [6:0] c0_q;
   logic [6:0] c0_d;
   logic good;
   assign good = |(REF_VALID_MASK & ~REF_FAILED);
   always_comb begin
      c0_d = c0_q;
      if (FSEL_WR && FSEL_ADDR == '0) c0_d = FSEL_WDATA[6:0];
   end
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) c0_q <= 7'h00;
      else c0_q <= c0_d;
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   AST_READBACK: assert property (FSEL_WR ##1 (!FSEL_WR && $stable(FSEL_ADDR))
      |=> FSEL_RDATA == $past(FSEL_WDATA, 2)) else $error("readback");
   AST_TIE_OR: assert property (1 |=> (ROUTE.tie_clear_en & $past(LOOP_TIE_CLR_REG))
      == $past(LOOP_TIE_CLR_REG)) else $error("tie or");
   AST_FAIL_OR: assert property (1 |=> REF_FAILED == $past(REF_MON_FAIL | ROUTE.loss_of_signal))
      else $error("failed or");
   AST_HOLD_NONE: assert property (!good && $stable(REF_VALID_MASK) |=> LOOP_HOLDOVER == 3'h7)
      else $error("holdover");
   AST_HOLD_GOOD: assert property (good && $stable(REF_VALID_MASK) |=> LOOP_HOLDOVER == 3'h0)
      else $error("no holdover");
   AST_QUIET: assert property ((GPIO_IN[NUM_PINS-1:1] == '0 && LOOP_TIE_CLR_REG == 3'h0 &&
      SYNTH_HALT_REG == 2'h0 && $stable(c0_q) && (!GPIO_IN[0] || c0_q == 7'h00 ||
      c0_q == 7'h21)) [*3] |=> ROUTE == '0) else $error("quiet");
   AST_PIN_HALT: assert property ((c0_q == 7'h44 && GPIO_IN[0]) [*3] |=> ROUTE.halt[1])
      else $error("pin halt");
   AST_PIN_LOS: assert property ((c0_q[6:3] == 4'h2 && GPIO_IN[0]) [*3]
      |=> ROUTE.loss_of_signal[c0_q[2:0]]) else $error("pin los");
   cover property (ROUTE.halt[1]);
   cover property (LOOP_HOLDOVER == 3'h7);
   cover property (|ROUTE.loss_of_signal);
endmodule : gcm_checker
bind gcm_top gcm_checker #(.NUM_PINS(NUM_PINS)) chk_u (.*);

// File: dv/tb_top.sv
// Self-checking bench for the pin function multiplexer
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wr = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wd = 8'h00;
   logic [7:0] rd;
   logic [6:0] want = 7'h00;
   logic [6:0] pins;
   logic [2:0] time_interval_error = 3'h0;
   logic [1:0] halt = 2'h0;
   logic [7:0] mon = 8'h00;
   logic [7:0] valid = 8'hFF;
   logic [8:0] act;
   logic [2:0] hold;
   logic [7:0] fail;
   gcm_pkg::gcm_route_s route;
   int n_fail = 0;
   int comparisons = 0;
   logic [7:0] code_r [16] = '{8'h0, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
      8'h20, 8'h28, 8'h30, 8'h44, 8'h45, 8'h21, 8'h80};
   logic [12:0] exp_r [16] = '{13'h0, 13'h20, 13'h40, 13'h80, 13'h100, 13'h200, 13'h400,
      13'h800, 13'h1000, 13'h4, 13'h8, 13'h10, 13'h2, 13'h1, 13'h0, 13'h0};
   always #50 clk = ~clk;
   gcm_board board_u (.clk(clk), .rst_n(rst_n), .want(want), .pins(pins));
   gcm_top dut_u (.CLK_SYS(clk), .RST_N(rst_n), .FSEL_WR(wr), .FSEL_ADDR(addr),
      .FSEL_WDATA(wd), .FSEL_RDATA(rd), .GPIO_IN(pins), .LOOP_TIE_CLR_REG(time_interval_error),
      .SYNTH_HALT_REG(halt), .REF_MON_FAIL(mon), .REF_VALID_MASK(valid),
      .LOOP_REF_SEL(9'h088), .ROUTE(route), .REF_FAILED(fail), .LOOP_ACTIVE_REF(act),
      .LOOP_HOLDOVER(hold));
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask : step
   task automatic wr_fsel(input logic [2:0] a, input logic [7:0] d);
      wr = 1'b1;
      addr = a;
      wd = d;
      step(1);
      wr = 1'b0;
   endtask : wr_fsel
   task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
      comparisons++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask : chk
   task automatic results;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : results
   initial begin
      step(10);
      rst_n = 1'b1;
      step(25);
      for (int i = 0; i < 16; i++) begin
         wr_fsel(3'h0, code_r[i]);
         want = 7'h01;
         step(5);
         chk("rdata", {5'h0, code_r[i]}, {5'h0, rd});
         chk("route", exp_r[i], route);
         chk("failed", {5'h0, exp_r[i][12:5]}, {5'h0, fail});
         want = 7'h00;
         step(5);
         chk("idle", 13'h0, route);
      end
      time_interval_error = 3'h5;
      halt = 2'h2;
      wr_fsel(3'h1, 8'h45);
      want = 7'h02;
      step(5);
      chk("or", 13'h17, route);
      time_interval_error = 3'h0;
      halt = 2'h0;
      wr_fsel(3'h1, 8'h10);
      step(6);
      chk("switch", 13'h089, {4'h0, act});
      valid = 8'hFD;
      step(3);
      chk("lowest", 13'h092, {4'h0, act});
      valid = 8'hFF;
      mon = 8'hFE;
      step(3);
      chk("holdover", 13'h7, {10'h0, hold});
      want = 7'h00;
      mon = 8'h00;
      rst_n = 1'b0;
      step(2);
      rst_n = 1'b1;
      step(2);
      chk("reset", 13'h0, {5'h0, rd});
      chk("reset route", 13'h0, route);
      chk("reset hold", 13'h0, {10'h0, hold});
      chk("reset act", 13'h088, {4'h0, act});
      results();
   end
endmodule : tb_top
